/* File: otp_status_map.vh */
// Command codes, status bit positions and timing constants for the OTP/status block
`ifndef OTP_STATUS_MAP_VH
`define OTP_STATUS_MAP_VH
// Command opcodes
`define CMD_RD_OTP 8'h4b
`define CMD_PROG_OTP 8'h9b
`define CMD_RD_SR1 8'h05
`define CMD_RD_SR2 8'h35
`define CMD_RD_SR3 8'h15
`define CMD_RD_IND 8'h65
// Opcode for the active status interrupt command (value is arbitrary)
`define CMD_ACT_STAT 8'h25
// Indirect status addresses
`define SR_ADDR1 8'h01
`define SR_ADDR2 8'h02
`define SR_ADDR3 8'h03
`define SR_ADDR6 8'h06
// Status register 1 bit positions
`define SR1_BUSY 0
`define SR1_WEL 1
// Status register 2 lock field, bits 5:3
`define SR2_LOCK_LO 3
`define SR2_LOCK_HI 5
// OTP address field
`define OTP_REG_HI 8
`define OTP_REG_LO 7
`define OTP_ADDR_W 9
`define OTP_DEPTH 512
`define OTP_USER_BASE 9'h080
// Top (lock) byte of user registers 1..3
`define OTP_TOP1 9'h0ff
`define OTP_TOP2 9'h17f
`define OTP_TOP3 9'h1ff
`define OTP_ERASED 8'hff
// Arbitrary factory pattern seed for register 0 (value is arbitrary)
`define OTP_FACTORY_SEED 8'h5a
// Program buffer
`define PBUF_DEPTH 256
`define PBUF_FULL 9'h100
// Address phase: three bytes for OTP commands
`define ADDR_LAST 2'h2
`define BIT_LAST 3'h7
// Programming time and clock period in ns
`define OTPP_TIME_NS 200000
`define CLK_PERIOD_NS 4
`endif

/* File: spi_pin_sync.v */
// Pin synchroniser and serial clock edge finder for the SPI pins
`timescale 1ns/100ps
module spi_pin_sync
(
  input wire sys_clk_i,
  input wire rst_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  output wire cs_n_o,
  output wire si_o,
  output wire sck_rise_o,
  output wire sck_fall_o,
  output wire cs_rise_o
);

////////////////////////////////////////////////////////////////////////
// Two stages per pin, a third for edge detection
reg [2:0] meta_ff; // First stage, read only by second
reg [2:0] sync_ff; // Second stage: {cs_n, sck, si}
reg [1:0] prev_ff; // Previous {cs_n, sck}

// All pins pass two flops before any logic reads them
always @(posedge sys_clk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    meta_ff <= 3'h4;
    sync_ff <= 3'h4;
    prev_ff <= 2'h2;
  end
  else
  begin
    meta_ff <= {cs_n_i, sck_i, si_i};
    sync_ff <= meta_ff;
    prev_ff <= sync_ff[2:1];
  end
end

////////////////////////////////////////////////////////////////////////
// Si shares the sck delay, so it is valid at the found edge
assign cs_n_o = sync_ff[2];
assign si_o = sync_ff[0];
assign sck_rise_o = sync_ff[1] & ~prev_ff[0];
assign sck_fall_o = ~sync_ff[1] & prev_ff[0];
assign cs_rise_o = sync_ff[2] & ~prev_ff[1];

endmodule // spi_pin_sync

/* File: otp_store.v */
// OTP security register array with bit-level programming and lock decode
`timescale 1ns/100ps
`include "otp_status_map.vh"
module otp_store
(
  input wire sys_clk_i,
  input wire rst_i,
  input wire [8:0] rd_addr_i,
  output wire [7:0] rd_data_o,
  input wire wr_en_i,
  input wire [8:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  output wire [2:0] lock_o
);

////////////////////////////////////////////////////////////////////////
reg [7:0] mem_ff [0:`OTP_DEPTH-1]; // Register 0 plus three user registers
integer i;

// Reset stands in for the non-volatile content: factory bytes get a
// fixed pattern, user bytes read erased. Programming only clears bits,
// so a programmed bit comes back only when reset reloads the array.
always @(posedge sys_clk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    for (i = 0; i < `OTP_DEPTH; i = i + 1)
    begin
      if (i < `OTP_USER_BASE)
        mem_ff[i] <= `OTP_FACTORY_SEED ^ i[7:0];
      else
        mem_ff[i] <= `OTP_ERASED;
    end
  end
  else if (wr_en_i)
  begin
    mem_ff[wr_addr_i] <= mem_ff[wr_addr_i] & wr_data_i;
  end
end

////////////////////////////////////////////////////////////////////////
assign rd_data_o = mem_ff[rd_addr_i];
// Any programmed bit in the top byte locks the register
assign lock_o[0] = mem_ff[`OTP_TOP1] != `OTP_ERASED;
assign lock_o[1] = mem_ff[`OTP_TOP2] != `OTP_ERASED;
assign lock_o[2] = mem_ff[`OTP_TOP3] != `OTP_ERASED;

endmodule // otp_store

/* File: otp_status_cmd.v */
// SPI command interpreter for OTP program/read and status register reads
//
// Operation
// - Busy flag shows OTP programming in progress
// - Write enable latch cleared before programming ends
// - Active status command streams live busy flag
// - OTP register zero always locked
// - Programmed top byte locks user register
// - Lower bytes allow bit-level repeated programming
// - Status two bits 5:3 show locks
// - Unaligned chip select release aborts programming
// - Incomplete address or data clears latch
// - Locked target register aborts programming
// - OTP and indirect reads are single-line
// - OTP read uses address bits 8:0
// - OTP bytes stream MSB first continuously
// - Direct reads return status one, two, three
// - Direct status read repeats with fresh data
// - Chip select release floats output immediately
// - Indirect read: address, dummy, then data
// - Indirect read continues while clocks arrive
// - Indirect address increments after each byte
// - Addresses 7-255 undefined, wrap at FFh
// - Programming starts after chip select release
`timescale 1ns/100ps
`include "otp_status_map.vh"
module otp_status_cmd
#(
  parameter PROG_CYCLES = `OTPP_TIME_NS / `CLK_PERIOD_NS
)
(
  input wire sys_clk_i,
  input wire rst_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  output wire so_o,
  output wire so_oe_n_o,
  input wire wel_set_i,
  input wire [47:0] status_fill_i,
  output wire busy_o,
  output wire wel_o
);

////////////////////////////////////////////////////////////////////////
// One-hot command states, plus the all-zero skip state
localparam ST_CMD = 8'h01; // Collect opcode
localparam ST_ADDR = 8'h02; // Collect address bytes
localparam ST_DUMMY = 8'h04; // Dummy byte
localparam ST_OTP = 8'h08; // Stream OTP bytes
localparam ST_SR = 8'h10; // Direct status repeat
localparam ST_IND = 8'h20; // Indirect status stream
localparam ST_PROG = 8'h40; // Collect program data
localparam ST_ASI = 8'h80; // Live busy on output; also unknown opcodes park in ST_CMD-free skip below
localparam ST_SKIP = 8'h00; // Unknown opcode: ignore rest of frame

// One-hot engine states
localparam EN_IDLE = 3'h1;
localparam EN_WRITE = 3'h2;
localparam EN_WAIT = 3'h4;

////////////////////////////////////////////////////////////////////////
wire cs_n_s; // Synchronised chip select
wire si_s; // Synchronised serial input
wire sck_rise; // Rising serial clock edge
wire sck_fall; // Falling serial clock edge
wire cs_rise; // Chip select release
wire [2:0] lock_w; // User register locks 3..1
wire [7:0] otp_rd; // OTP read data
reg [7:0] state_ff; // Command state
reg [7:0] cmd_ff; // Opcode of this frame
reg [2:0] bit_cnt_ff; // Bits taken within current byte
reg [1:0] byte_cnt_ff; // Address bytes taken
reg [6:0] sh_ff; // Input shift register
reg [15:0] addr_ff; // Upper address bytes
reg [8:0] optr_ff; // OTP read pointer
reg [7:0] iptr_ff; // Indirect status pointer
reg [7:0] sr_sel_ff; // Direct status selection
reg [8:0] pstart_ff; // Program start address
reg [8:0] pcount_ff; // Buffered byte count
reg [7:0] pbuf [0:`PBUF_DEPTH-1]; // Program page buffer
reg so_ff; // Output bit
reg [2:0] eng_ff; // Program engine state
reg [8:0] pidx_ff; // Engine byte index
reg [19:0] timer_ff; // Self-timed programming counter
reg busy_ff; // Ready/busy flag
reg wel_ff; // Write enable latch
wire [7:0] in_byte; // Byte completed on this edge
wire [7:0] sr1_w; // Status register 1
wire [7:0] sr2_w; // Status register 2
wire [47:0] stat_w; // All six status registers
reg [7:0] cur_byte; // Byte being shifted out
wire launch; // Accepted program at release
wire abort_wel; // Aborted program clearing latch
wire [8:0] wr_addr; // Engine write target
wire wr_en; // Engine store write

////////////////////////////////////////////////////////////////////////
// Locked if register 0, else the lock bit of the user register
function reg_locked;
  input [1:0] sel;
  input [2:0] locks;
  reg [3:0] all_locks; // Register 0 is the always-set bottom bit
  begin
    all_locks = {locks, 1'b1};
    reg_locked = all_locks[sel];
  end
endfunction

// Status byte by indirect address; anything outside 1..6 reads zero
function [7:0] status_pick;
  input [7:0] a;
  input [47:0] s;
  reg [47:0] shifted; // Selected byte moved to the bottom
  begin
    shifted = 48'h000000000000;
    if (a >= `SR_ADDR1 && a <= `SR_ADDR6)
    begin
      shifted = s >> {a[2:0] - 3'h1, 3'h0};
      status_pick = shifted[7:0];
    end
    else
      status_pick = 8'h00;
  end
endfunction

////////////////////////////////////////////////////////////////////////
spi_pin_sync u_sync
(
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .cs_n_i(cs_n_i),
  .sck_i(sck_i),
  .si_i(si_i),
  .cs_n_o(cs_n_s),
  .si_o(si_s),
  .sck_rise_o(sck_rise),
  .sck_fall_o(sck_fall),
  .cs_rise_o(cs_rise)
);

otp_store u_store
(
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .rd_addr_i(optr_ff),
  .rd_data_o(otp_rd),
  .wr_en_i(wr_en),
  .wr_addr_i(wr_addr),
  .wr_data_i(pbuf[pidx_ff[7:0]]),
  .lock_o(lock_w)
);

////////////////////////////////////////////////////////////////////////
// Status view: busy, latch and locks overlay the outside fill bits
assign sr1_w = {status_fill_i[7:2], wel_ff, busy_ff};
assign sr2_w = {status_fill_i[15:14], lock_w, status_fill_i[10:8]};
assign stat_w = {status_fill_i[47:16], sr2_w, sr1_w};
assign in_byte = {sh_ff, si_s};

// Byte to shift out in the current data state
always @*
begin
  case (state_ff)
    ST_OTP: cur_byte = otp_rd;
    ST_SR: cur_byte = status_pick(sr_sel_ff, stat_w);
    ST_IND: cur_byte = status_pick(iptr_ff, stat_w);
    default: cur_byte = 8'h00;
  endcase
end

////////////////////////////////////////////////////////////////////////
// Command FSM; input is taken on rising sck edges only
always @(posedge sys_clk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    state_ff <= ST_CMD;
    cmd_ff <= 8'h00;
    bit_cnt_ff <= 3'h0;
    byte_cnt_ff <= 2'h0;
    sh_ff <= 7'h00;
    addr_ff <= 16'h0000;
    optr_ff <= 9'h000;
    iptr_ff <= 8'h00;
    sr_sel_ff <= 8'h00;
    pstart_ff <= 9'h000;
    pcount_ff <= 9'h000;
  end
  else if (cs_n_s)
  begin
    // Release ends any frame, mid-byte included
    state_ff <= ST_CMD;
    bit_cnt_ff <= 3'h0;
    byte_cnt_ff <= 2'h0;
  end
  else if (sck_rise)
  begin
    bit_cnt_ff <= bit_cnt_ff + 3'h1;
    sh_ff <= in_byte[6:0];
    if (bit_cnt_ff == `BIT_LAST)
    begin
      case (state_ff)
        ST_CMD:
        begin
          cmd_ff <= in_byte;
          byte_cnt_ff <= 2'h0;
          pcount_ff <= (in_byte == `CMD_PROG_OTP) ? 9'h000 : pcount_ff;
          if (in_byte == `CMD_RD_OTP || in_byte == `CMD_PROG_OTP || in_byte == `CMD_RD_IND)
            state_ff <= ST_ADDR;
          else if (in_byte == `CMD_RD_SR1)
          begin
            state_ff <= ST_SR;
            sr_sel_ff <= `SR_ADDR1;
          end
          else if (in_byte == `CMD_RD_SR2)
          begin
            state_ff <= ST_SR;
            sr_sel_ff <= `SR_ADDR2;
          end
          else if (in_byte == `CMD_RD_SR3)
          begin
            state_ff <= ST_SR;
            sr_sel_ff <= `SR_ADDR3;
          end
          else if (in_byte == `CMD_ACT_STAT)
            state_ff <= ST_ASI;
          else
            state_ff <= ST_SKIP;
        end
        ST_ADDR:
        begin
          addr_ff <= {addr_ff[7:0], in_byte};
          byte_cnt_ff <= byte_cnt_ff + 2'h1;
          if (cmd_ff == `CMD_RD_IND)
          begin
            iptr_ff <= in_byte;
            state_ff <= ST_DUMMY;
          end
          else if (byte_cnt_ff == `ADDR_LAST)
          begin
            // Bits 23:9 are dropped here
            optr_ff <= {addr_ff[0], in_byte};
            pstart_ff <= {addr_ff[0], in_byte};
            state_ff <= (cmd_ff == `CMD_PROG_OTP) ? ST_PROG : ST_DUMMY;
          end
        end
        ST_DUMMY: state_ff <= (cmd_ff == `CMD_RD_OTP) ? ST_OTP : ST_IND;
        ST_OTP: optr_ff <= optr_ff + 9'h001;
        ST_IND: iptr_ff <= iptr_ff + 8'h01;
        ST_PROG:
        begin
          // Count holds at a full buffer, so later bytes all overwrite entry 0
          if (pcount_ff != `PBUF_FULL)
            pcount_ff <= pcount_ff + 9'h001;
        end
        default: state_ff <= state_ff;
      endcase
    end
  end
end

// Page buffer fill; index goes to entry 0 and stays there once the 256-byte buffer is full
always @(posedge sys_clk_i)
begin
  if (!cs_n_s && sck_rise && bit_cnt_ff == `BIT_LAST && state_ff == ST_PROG)
    pbuf[pcount_ff[7:0]] <= in_byte;
end

////////////////////////////////////////////////////////////////////////
// Output bit changes on falling sck; active status follows busy live
always @(posedge sys_clk_i or posedge rst_i)
begin
  if (rst_i)
    so_ff <= 1'b0;
  else if (state_ff == ST_ASI)
    so_ff <= busy_ff;
  else if (sck_fall)
    so_ff <= cur_byte[~bit_cnt_ff];
end

// Drive only in data states and only while selected
assign so_oe_n_o = cs_n_s | ~(state_ff == ST_OTP || state_ff == ST_SR ||
                              state_ff == ST_IND || state_ff == ST_ASI);
assign so_o = so_ff;

////////////////////////////////////////////////////////////////////////
// Release decisions for a program frame
assign launch = cs_rise && state_ff == ST_PROG && bit_cnt_ff == 3'h0 &&
                pcount_ff != 9'h000 && wel_ff && !busy_ff &&
                !reg_locked(pstart_ff[`OTP_REG_HI:`OTP_REG_LO], lock_w);
assign abort_wel = cs_rise && ((state_ff == ST_PROG && bit_cnt_ff != 3'h0) ||
                               (state_ff == ST_ADDR && cmd_ff == `CMD_PROG_OTP));
assign wr_addr = pstart_ff + pidx_ff;
// Bytes landing in a locked or factory register are skipped
assign wr_en = eng_ff == EN_WRITE &&
               !reg_locked(wr_addr[`OTP_REG_HI:`OTP_REG_LO], lock_w);

// Program engine: write buffered bytes, then wait out the program time
always @(posedge sys_clk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    eng_ff <= EN_IDLE;
    busy_ff <= 1'b0;
    wel_ff <= 1'b0;
    pidx_ff <= 9'h000;
    timer_ff <= 20'h00000;
  end
  else
  begin
    case (eng_ff)
      EN_IDLE:
      begin
        // A set arriving with an abort wins over the clear
        if (wel_set_i)
          wel_ff <= 1'b1;
        else if (abort_wel)
          wel_ff <= 1'b0;
        if (launch)
        begin
          busy_ff <= 1'b1;
          pidx_ff <= 9'h000;
          eng_ff <= EN_WRITE;
        end
      end
      EN_WRITE:
      begin
        pidx_ff <= pidx_ff + 9'h001;
        if (pidx_ff == pcount_ff - 9'h001)
        begin
          wel_ff <= 1'b0;
          timer_ff <= PROG_CYCLES[19:0] - 20'h00001;
          eng_ff <= EN_WAIT;
        end
      end
      EN_WAIT:
      begin
        timer_ff <= timer_ff - 20'h00001;
        if (timer_ff == 20'h00000)
        begin
          busy_ff <= 1'b0;
          eng_ff <= EN_IDLE;
        end
      end
      default: eng_ff <= EN_IDLE;
    endcase
  end
end

assign busy_o = busy_ff;
assign wel_o = wel_ff;

endmodule // otp_status_cmd

/* File: otp_status_cmd_chk.sv */
// Port-level checker for the OTP and status command block
`timescale 1ns/100ps
module otp_status_cmd_chk
#(
  parameter PROG_CYCLES = 20
)
(
  input wire sys_clk_i,
  input wire rst_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  input wire so_o,
  input wire so_oe_n_o,
  input wire wel_set_i,
  input wire [47:0] status_fill_i,
  input wire busy_o,
  input wire wel_o
);
  // Length of the current busy window
  reg [31:0] busy_cnt_ff;
  ////////////////////////////////////////////////////////////
  // Count busy cycles; restarts whenever busy drops
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      busy_cnt_ff <= 32'h0;
    else if (busy_o)
      busy_cnt_ff <= busy_cnt_ff + 32'h1;
    else
      busy_cnt_ff <= 32'h0;
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // Released select must float the output within the sync delay
  property p_float_off;
    cs_n_i [*5] |-> so_oe_n_o;
  endproperty
  a_float_off: assert property (p_float_off) else $error("output driven outside frame");
  // Data states open on the last rising clock of the preceding phase, so the pin clock is still high
  property p_oe_start;
    $fell(so_oe_n_o) |-> !cs_n_i && !$past(cs_n_i, 2) && sck_i;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("output enabled off frame");
  // Output only lets go once select has gone high
  property p_oe_end;
    $rose(so_oe_n_o) |-> cs_n_i && $past(cs_n_i, 2);
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("output released inside frame");
  // The live busy view loads its first value one cycle after the output opens
  property p_so_on_fall;
    $changed(so_o) && !so_oe_n_o && !$past(so_oe_n_o, 2) |-> !sck_i;
  endproperty
  a_so_on_fall: assert property (p_so_on_fall) else $error("output moved with clock high");
  property p_busy_start;
    $rose(busy_o) |-> cs_n_i && $past(cs_n_i, 2);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy rose inside frame");
  // Up to 256 buffered writes plus the self-timed cycle
  property p_busy_len;
    busy_o |-> busy_cnt_ff < PROG_CYCLES + 300;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy held too long");
  property p_wel_done;
    $fell(busy_o) |-> !wel_o;
  endproperty
  a_wel_done: assert property (p_wel_done) else $error("latch still set at end");
  property p_wel_drop;
    $fell(wel_o) |-> cs_n_i && $past(cs_n_i);
  endproperty
  a_wel_drop: assert property (p_wel_drop) else $error("latch cleared inside frame");
endmodule // otp_status_cmd_chk

bind otp_status_cmd otp_status_cmd_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o), .wel_set_i(wel_set_i),
  .status_fill_i(status_fill_i), .busy_o(busy_o), .wel_o(wel_o));

/* File: spi_host_model.sv */
// Behavioural SPI host in mode 0 driving the block's serial pins
`timescale 1ns/100ps
module spi_host_model
(
  input wire sys_clk_i,
  input wire so_i,
  output reg cs_n_o,
  output reg sck_o,
  output reg si_o
);
  // Half of the 160 ns serial clock, in system clocks
  localparam HALF = 20;
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Wait n falling system edges; all pin changes land there
  task hold(input integer n);
  begin
    repeat (n) @(negedge sys_clk_i);
  end
  endtask
  // Shift the top n bits of b, MSB first; capture output at each rise
  task shift(input [7:0] b, input integer n, output [7:0] r);
    integer i;
  begin
    r = 8'h00;
    for (i = 7; i > 7 - n; i = i - 1)
    begin
      si_o = b[i];
      hold(HALF);
      sck_o = 1'b1;
      r[i] = so_i;
      hold(HALF);
      sck_o = 1'b0;
    end
  end
  endtask
  // Opcode, na address bytes from the top, nd dummy bytes
  task cmd(input [7:0] op, input [23:0] a, input integer na, input integer nd);
    integer j;
    reg [7:0] x;
  begin
    cs_n_o = 1'b0;
    hold(HALF);
    shift(op, 8, x);
    for (j = na; j > 0; j = j - 1)
      shift(a[8*j-1 -: 8], 8, x);
    for (j = 0; j < nd; j = j + 1)
      shift(8'h00, 8, x);
  end
  endtask
  // Release select; input toggled so a stale level is never trusted
  task close_frame;
  begin
    hold(HALF);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    hold(HALF);
  end
  endtask
endmodule // spi_host_model

/* File: otp_security_and_status_read_test.sv */
// Self-checking bench for the OTP and status command block
`timescale 1ns/100ps
`include "otp_status_map.vh"
module otp_security_and_status_read_test;
  // Shortened program time so a busy window spans a few polls
  localparam PROG = 2000;
  reg sys_clk_i;
  reg rst_i;
  reg wel_set_i;
  reg [47:0] status_fill_i;
  wire cs_n;
  wire sck;
  wire si;
  wire so;
  wire so_oe_n;
  wire busy;
  wire write_enable_latch;
  integer mismatches;
  integer n_tests;
  integer cycles;
  integer i;
  integer k;
  reg [7:0] r;
  // Rows: opcode, address, first byte, second byte
  reg [31:0] rows [0:8];
  ////////////////////////////////////////////////////////////
  otp_status_cmd #(.PROG_CYCLES(PROG)) uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n), .wel_set_i(wel_set_i), .status_fill_i(status_fill_i),
    .busy_o(busy), .wel_o(write_enable_latch));
  spi_host_model host (.sys_clk_i(sys_clk_i), .so_i(so), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // Hang guard, well above the roughly 46k cycles of the run
  always @(posedge sys_clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 90000)
    begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  ////////////////////////////////////////////////////////////
  task chk(input string what, input [7:0] e, input [7:0] g);
  begin
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", what, e, g);
      mismatches = mismatches + 1;
    end
  end
  endtask
  // One frame reading two bytes
  task rd2(input [7:0] op, input [23:0] a, input integer na, input integer nd, input [7:0] e0, input [7:0] e1);
  begin
    host.cmd(op, a, na, nd);
    host.shift(8'h00, 8, r);
    chk("first byte", e0, r);
    host.shift(8'h00, 8, r);
    chk("second byte", e1, r);
    host.close_frame;
  end
  endtask
  // Set the latch, then program one byte plus nb stray bits
  task prog(input [23:0] a, input [7:0] d, input integer nb);
  begin
    wel_set_i = 1'b1;
    @(negedge sys_clk_i);
    wel_set_i = 1'b0;
    host.cmd(`CMD_PROG_OTP, a, 3, 0);
    host.shift(d, 8, r);
    if (nb > 0)
      host.shift(8'h00, nb, r);
    host.close_frame;
  end
  endtask
  // Poll the busy flag instead of sitting out the full time
  task wait_idle;
  begin
    k = 0;
    r = 8'h01;
    while (r[0] !== 1'b0 && k < 40)
    begin
      host.cmd(`CMD_RD_SR1, 24'h0, 0, 0);
      host.shift(8'h00, 8, r);
      host.close_frame;
      k = k + 1;
    end
    chk("busy done", 8'h00, {7'h0, r[0]});
  end
  endtask
  task give_verdict;
  begin
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    rst_i = 1'b1;
    wel_set_i = 1'b0;
    status_fill_i = 48'ha69584_73e2d1;
    rows[0] = 32'h0500d0d0;
    rows[1] = 32'h3500c2c2;
    rows[2] = 32'h15007373;
    rows[3] = 32'h6501d0c2;
    rows[4] = 32'h6502c273;
    rows[5] = 32'h65037384;
    rows[6] = 32'h65048495;
    rows[7] = 32'h650595a6;
    rows[8] = 32'h6506a600;
    repeat (10) @(negedge sys_clk_i);
    rst_i = 1'b0;
    chk("reset state", 8'h01, {5'h0, busy, write_enable_latch, so_oe_n});
    for (i = 0; i < 9; i = i + 1)
      rd2(rows[i][31:24], {16'h0, rows[i][23:16]}, rows[i][31:24] == `CMD_RD_IND ? 1 : 0,
        rows[i][31:24] == `CMD_RD_IND ? 1 : 0, rows[i][15:8], rows[i][7:0]);
    // Address ff wraps to 00 and then to register one
    host.cmd(`CMD_RD_IND, 24'hff, 1, 1);
    host.shift(8'h00, 8, r);
    chk("undefined byte", 8'h00, r);
    host.shift(8'h00, 8, r);
    host.shift(8'h00, 8, r);
    chk("wrapped byte", 8'hd0, r);
    host.close_frame;
    // Mid-byte release
    host.cmd(`CMD_RD_SR1, 24'h0, 0, 0);
    host.shift(8'h00, 3, r);
    host.close_frame;
    chk("float", 8'h01, {7'h0, so_oe_n});
    prog(24'h000100, 8'h3c, 0);
    chk("busy launch", 8'h01, {7'h0, busy});
    host.cmd(`CMD_RD_SR1, 24'h0, 0, 0);
    host.shift(8'h00, 8, r);
    host.close_frame;
    chk("busy bit", 8'h01, {7'h0, r[0]});
    wait_idle;
    chk("latch end", 8'h00, {7'h0, write_enable_latch});
    rd2(`CMD_RD_OTP, 24'hfe0100, 3, 1, 8'h3c, 8'hff);
    // Second pass on the same byte, watched on the live flag
    prog(24'h000100, 8'hf0, 0);
    host.cmd(`CMD_ACT_STAT, 24'h0, 0, 0);
    host.hold(20);
    chk("live busy", 8'h01, {7'h0, so});
    k = 0;
    while (busy !== 1'b0 && k < 9000)
    begin
      @(negedge sys_clk_i);
      k = k + 1;
    end
    host.hold(4);
    chk("busy fall", 8'h00, {7'h0, so});
    host.close_frame;
    rd2(`CMD_RD_OTP, 24'h000100, 3, 1, 8'h30, 8'hff);
    prog(24'h0000ff, 8'h7f, 0);
    wait_idle;
    rd2(`CMD_RD_SR2, 24'h0, 0, 0, 8'hca, 8'hca);
    prog(24'h000080, 8'h00, 0);
    wait_idle;
    rd2(`CMD_RD_OTP, 24'h000080, 3, 1, 8'hff, 8'hff);
    prog(24'h000005, 8'h00, 0);
    wait_idle;
    rd2(`CMD_RD_OTP, 24'h000005, 3, 1, 8'h5f, 8'h5c);
    prog(24'h000101, 8'h00, 3);
    chk("abort latch", 8'h00, {6'h0, write_enable_latch, busy});
    rd2(`CMD_RD_OTP, 24'h000101, 3, 1, 8'hff, 8'hff);
    give_verdict;
  end
endmodule // otp_security_and_status_read_test
